// *** src/psrb_pkg.sv ***
// Shared constants and types of the partition statistics response builder.
// Assumes a single pclk domain and an APB master for the registers.
package psrb_pkg;
    // Response type carried by every statistics response
    localparam logic [7:0] PSRB_RESP_TYPE = 8'hAF;
    // Stats type codes; arbitrary defaults, set by the top parameters
    localparam logic [7:0] PSRB_FAB_CODE_DFLT = 8'h01;
    localparam logic [7:0] PSRB_RDMA_CODE_DFLT = 8'h02;
    // Word positions inside a response
    localparam logic [4:0] PSRB_W_RESP = 5'h04;
    localparam logic [4:0] PSRB_W_TYPE = 5'h05;
    localparam logic [4:0] PSRB_W_CNT0 = 5'h06;
    localparam logic [4:0] PSRB_W_FAB_SUM = 5'h0E;
    localparam logic [4:0] PSRB_W_RDMA_SUM = 5'h14;
    // Counter counts
    localparam int PSRB_FAB_CNT = 8;
    localparam int PSRB_RDMA_CNT = 7;
    localparam int PSRB_FLAG_W = 15;
    // Cleared flag vector layout: fabric low, RDMA above
    localparam int PSRB_FLAG_FAB_LSB = 0;
    localparam int PSRB_FLAG_RDMA_LSB = 8;
    localparam logic [14:0] PSRB_FAB_MASK = 15'h00FF;
    localparam logic [14:0] PSRB_RDMA_MASK = 15'h7F00;
    // Reason codes with this bit set are command specific
    localparam int PSRB_REASON_CS_BIT = 15;
    // Register byte addresses
    localparam logic [11:0] PSRB_ADDR_CTRL = 12'h000;
    localparam logic [11:0] PSRB_ADDR_SIZES = 12'h004;
    localparam logic [11:0] PSRB_ADDR_STATUS = 12'h008;
    localparam logic [11:0] PSRB_ADDR_FLAGS = 12'h00C;
    localparam logic [11:0] PSRB_ADDR_SENT = 12'h010;
    // Field positions and reset values
    localparam int PSRB_CTRL_EN_BIT = 0;
    localparam int PSRB_STATUS_BUSY_BIT = 0;
    localparam logic PSRB_CTRL_EN_RST = 1'b1;
    localparam logic [6:0] PSRB_SIZES_RST = 7'h7F;
    localparam logic [15:0] PSRB_SENT_RST = 16'h0000;

    typedef enum logic [0:0] {PSRB_IDLE, PSRB_SEND} psrb_state_type;
endpackage

// *** src/psrb_side_if.sv ***
// Links the framer core to its flag tracker and checksum accumulator.
// Assumes all three parties run on the same pclk.
`timescale 1ns/1ps
`default_nettype none
interface psrb_side_if;
    logic [14:0] clr_ev;
    logic take;
    logic [14:0] take_mask;
    logic [14:0] flags;
    logic sum_clr;
    logic sum_add;
    logic [31:0] sum_word;
    logic [31:0] sum_neg;
    modport core (output clr_ev, take, take_mask, sum_clr, sum_add, sum_word,
                  input flags, sum_neg);
    modport trk (input clr_ev, take, take_mask, output flags);
    modport chk (input sum_clr, sum_add, sum_word, output sum_neg);
endinterface
`default_nettype wire

// *** src/psrb_flag_track.sv ***
// Sticky counters-cleared flags, one per reported counter.
// Assumes clr_ev pulses one cycle per clear and take pulses at packet end.
`timescale 1ns/1ps
`default_nettype none
module psrb_flag_track
    import psrb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    psrb_side_if.trk side
);
    typedef struct packed {
        logic [14:0] flags;
    } psrb_trk_type;

    psrb_trk_type r;
    psrb_trk_type next_r;

    always_comb begin
        next_r = r;
        // RULE5 set wins over clear
        // RULE11 reported flags drop
        next_r.flags = (r.flags & ~(side.take ? side.take_mask : 15'h0000)) | side.clr_ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign side.flags = r.flags;

    a_clear_sets_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        (|side.clr_ev) |=> ((r.flags & $past(side.clr_ev)) == $past(side.clr_ev)))
        else $error("cleared event lost");
    a_take_drops_flag: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        side.take |=> ((r.flags & $past(side.take_mask) & ~$past(side.clr_ev)) == 15'h0000))
        else $error("reported flag not dropped");
endmodule
`default_nettype wire

// *** src/psrb_csum.sv ***
// Checksum accumulator over the 16-bit halves of the words sent so far.
// Assumes sum_clr precedes the first sum_add of a packet.
`timescale 1ns/1ps
`default_nettype none
module psrb_csum
    import psrb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    psrb_side_if.chk side
);
    typedef struct packed {
        logic [31:0] sum;
    } psrb_sum_type;

    psrb_sum_type r;
    psrb_sum_type next_r;

    always_comb begin
        next_r = r;
        if (side.sum_clr) begin
            next_r.sum = 32'h0000_0000;
        end else if (side.sum_add) begin
            next_r.sum = r.sum + {16'h0000, side.sum_word[31:16]} + {16'h0000, side.sum_word[15:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Two's complement so that the whole packet sums to zero
    assign side.sum_neg = ~r.sum + 32'h0000_0001;
endmodule
`default_nettype wire

// *** src/psrb_builder.sv ***
// Partition statistics response framer with an APB register slave.
// Assumes counters and clear events arrive synchronous to pclk and that
// the response sink applies back-pressure through tx_ready.
//
// Notes on behaviour
// RULE1 - A fabric stats request without error yields a 0xAF response in fabric format.
// RULE2 - No command specific reason code is ever placed in these responses.
// RULE3 - Bytes 0-15 carry the header, 16-19 response and reason, 20-23 type, zero and flags.
// RULE4 - Bytes 24-55 carry the eight fabric counters in order, the checksum in bytes 56-59.
// RULE5 - Each cleared flag is set when its counter was cleared since the last report.
// RULE6 - Fabric flag bits 0-7 follow counter order and bits 15-8 are zero.
// RULE7 - An RDMA stats request without error yields a response in RDMA format.
// RULE8 - Bytes 24-79 carry seven RDMA counters upper then lower, checksum in bytes 80-83.
// RULE9 - A counter size bitmap reports each RDMA counter as 32 or 64 bit, bit 7 zero.
// RULE10 - RDMA flag bits 0-6 follow counter order and bits 15-7 are zero.
// RULE11 - A flag drops once its counter was returned, and reserved bits are zero.
// RULE12 - A 32-bit RDMA counter goes in the lower word with the upper word zero.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module psrb_builder
    import psrb_pkg::*;
#(
    parameter logic [7:0] FAB_CODE = PSRB_FAB_CODE_DFLT,
    parameter logic [7:0] RDMA_CODE = PSRB_RDMA_CODE_DFLT
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_stats_type,
    input wire logic [127:0] req_header,
    input wire logic [15:0] req_resp_code,
    input wire logic [15:0] req_reason_code,
    input wire logic [255:0] fab_count,
    input wire logic [447:0] rdma_count,
    input wire logic [7:0] fab_cleared,
    input wire logic [6:0] rdma_cleared,
    output logic tx_valid,
    output logic [31:0] tx_data,
    output logic tx_last,
    output logic [7:0] tx_resp_type,
    input wire logic tx_ready
);
    if (FAB_CODE == RDMA_CODE) begin : g_bad_codes
        $error("stats type codes must differ");
    end

    // Word and flag positions must agree with the counter counts
    if (int'(PSRB_W_FAB_SUM) != int'(PSRB_W_CNT0) + PSRB_FAB_CNT) begin : g_bad_fab
        $error("fabric word layout inconsistent");
    end
    if (int'(PSRB_W_RDMA_SUM) != int'(PSRB_W_CNT0) + 2 * PSRB_RDMA_CNT) begin : g_bad_rdma
        $error("RDMA word layout inconsistent");
    end
    if (PSRB_FLAG_RDMA_LSB + PSRB_RDMA_CNT != PSRB_FLAG_W) begin : g_bad_flags
        $error("flag vector layout inconsistent");
    end

    typedef struct packed {
        psrb_state_type st;
        logic [4:0] idx;
        logic rdma;
        logic [7:0] stype;
        logic [127:0] hdr;
        logic [31:0] rr;
        logic [14:0] snap;
        logic tx_valid;
        logic [31:0] tx_data;
        logic tx_last;
        logic [7:0] tx_type;
        logic req_ready;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic en;
        logic [6:0] sizes;
        logic [15:0] sent;
    } psrb_core_type;

    psrb_core_type r;
    psrb_core_type next_r;
    psrb_side_if side ();

    default clocking psrb_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    psrb_flag_track u_track (
        .pclk(pclk),
        .presetn(presetn),
        .side(side.trk)
    );

    psrb_csum u_csum (
        .pclk(pclk),
        .presetn(presetn),
        .side(side.chk)
    );

    // One 32-bit slice of a packed counter vector
    function automatic logic [31:0] psrb_slice(input logic [447:0] v, input logic [3:0] k);
        return v[{k, 5'b00000} +: 32];
    endfunction

    // Content of word idx of the response being built
    function automatic logic [31:0] psrb_word(input psrb_core_type s, input logic [14:0] fl,
                                              input logic [255:0] fc, input logic [447:0] rc,
                                              input logic [31:0] neg);
        logic [3:0] j;
        logic [1:0] hw;
        logic [31:0] w;
        j = 4'(s.idx - PSRB_W_CNT0);
        hw = 2'd3 - s.idx[1:0];
        w = 32'h0000_0000;
        if (s.idx < PSRB_W_RESP) begin
            w = s.hdr[{hw, 5'b00000} +: 32];
        end else if (s.idx == PSRB_W_RESP) begin
            w = s.rr;
        end else if (s.idx == PSRB_W_TYPE) begin
            // RULE6 fabric flag layout
            // RULE9 size bitmap, bit 7 zero
            // RULE10 RDMA flag layout
            if (s.rdma) begin
                w = {s.stype, 1'b0, s.sizes, 9'h000, fl[PSRB_FLAG_RDMA_LSB +: PSRB_RDMA_CNT]};
            end else begin
                w = {s.stype, 16'h0000, fl[PSRB_FLAG_FAB_LSB +: PSRB_FAB_CNT]};
            end
        end else if (!s.rdma && s.idx < PSRB_W_FAB_SUM) begin
            // RULE4 fabric counters in order
            w = psrb_slice({192'h0, fc}, j);
        end else if (s.rdma && s.idx < PSRB_W_RDMA_SUM) begin
            // RULE8 upper word then lower word
            // RULE12 narrow counter upper word zero
            if (!j[0] && !s.sizes[j[3:1]]) begin
                w = 32'h0000_0000;
            end else begin
                w = psrb_slice(rc, j ^ 4'h1);
            end
        end else begin
            w = neg;
        end
        return w;
    endfunction

    logic [4:0] last_idx;
    logic [4:0] cur_idx;
    logic [7:0] known;
    assign last_idx = r.rdma ? PSRB_W_RDMA_SUM : PSRB_W_FAB_SUM;
    assign cur_idx = r.idx - 5'd1;
    assign known = req_stats_type;
    assign side.clr_ev = {rdma_cleared, fab_cleared};

    always_comb begin
        next_r = r;
        side.take = 1'b0;
        side.take_mask = r.snap;
        side.sum_clr = 1'b0;
        side.sum_add = 1'b0;
        side.sum_word = 32'h0000_0000;
        next_r.pready = 1'b0;
        next_r.pslverr = 1'b0;
        // Read data is captured in the setup cycle, so it is one cycle old
        if (psel && !penable) begin
            next_r.pready = 1'b1;
            next_r.prdata = 32'h0000_0000;
            if (paddr == PSRB_ADDR_CTRL) begin
                next_r.prdata[PSRB_CTRL_EN_BIT] = r.en;
            end else if (paddr == PSRB_ADDR_SIZES) begin
                next_r.prdata[6:0] = r.sizes;
            end else if (paddr == PSRB_ADDR_STATUS) begin
                next_r.prdata[PSRB_STATUS_BUSY_BIT] = (r.st == PSRB_SEND);
            end else if (paddr == PSRB_ADDR_FLAGS) begin
                next_r.prdata[14:0] = side.flags;
            end else if (paddr == PSRB_ADDR_SENT) begin
                next_r.prdata[15:0] = r.sent;
            end else begin
                next_r.pslverr = 1'b1;
            end
        end
        if (psel && penable && r.pready && pwrite && !r.pslverr && pstrb[0]) begin
            if (paddr == PSRB_ADDR_CTRL) begin
                next_r.en = pwdata[PSRB_CTRL_EN_BIT];
            end else if (paddr == PSRB_ADDR_SIZES) begin
                next_r.sizes = pwdata[6:0];
            end
        end
        case (r.st)
            PSRB_IDLE: begin
                // RULE1 fabric request accepted
                // RULE7 RDMA request accepted
                if (r.req_ready && req_valid && (known == FAB_CODE || known == RDMA_CODE)) begin
                    next_r.st = PSRB_SEND;
                    next_r.idx = 5'd0;
                    next_r.rdma = (known == RDMA_CODE);
                    next_r.stype = known;
                    next_r.hdr = req_header;
                    // RULE2 command specific reasons replaced by zero
                    next_r.rr = {req_resp_code, req_reason_code[PSRB_REASON_CS_BIT] ? 16'h0000
                                                                                   : req_reason_code};
                    next_r.snap = side.flags & ((known == RDMA_CODE) ? PSRB_RDMA_MASK
                                                                     : PSRB_FAB_MASK);
                    side.sum_clr = 1'b1;
                end
            end
            PSRB_SEND: begin
                // RULE5 a clear in flight keeps its flag
                next_r.snap = r.snap & ~side.clr_ev;
                if (r.tx_valid && tx_ready && r.tx_last) begin
                    // RULE11 flags reported, drop them
                    side.take = 1'b1;
                    next_r.st = PSRB_IDLE;
                    next_r.tx_valid = 1'b0;
                    next_r.tx_last = 1'b0;
                    next_r.sent = r.sent + 16'h0001;
                end else if (!r.tx_valid || (tx_ready && !r.tx_last)) begin
                    // RULE3 header, codes and type word in place
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data = psrb_word(r, side.flags, fab_count, rdma_count, side.sum_neg);
                    next_r.tx_last = (r.idx == last_idx);
                    side.sum_add = (r.idx != last_idx);
                    side.sum_word = next_r.tx_data;
                    next_r.idx = r.idx + 5'd1;
                end
            end
            default: begin
                next_r.st = PSRB_IDLE;
            end
        endcase
        next_r.req_ready = (next_r.st == PSRB_IDLE) && next_r.en;
        // RULE1 response type tag
        next_r.tx_type = next_r.tx_valid ? PSRB_RESP_TYPE : 8'h00;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= PSRB_IDLE;
            r.en <= PSRB_CTRL_EN_RST;
            r.sizes <= PSRB_SIZES_RST;
            r.sent <= PSRB_SENT_RST;
        end else begin
            r <= next_r;
        end
    end

    assign pready = r.pready;
    assign prdata = r.prdata;
    assign pslverr = r.pslverr;
    assign req_ready = r.req_ready;
    assign tx_valid = r.tx_valid;
    assign tx_data = r.tx_data;
    assign tx_last = r.tx_last;
    assign tx_resp_type = r.tx_type;

    a_resp_type_tag: assert property ( // RULE1
        tx_valid |-> tx_resp_type == 8'hAF)
        else $error("response type not 0xAF");
    a_reason_generic: assert property ( // RULE2
        tx_valid && cur_idx == 5'd4 |-> !tx_data[15])
        else $error("command specific reason sent");
    a_type_word: assert property ( // RULE3
        tx_valid && cur_idx == 5'd5 |-> tx_data[31:24] == r.stype)
        else $error("stats type misplaced");
    a_fab_length: assert property ( // RULE4
        tx_valid && tx_last && !r.rdma |-> cur_idx == 5'd14)
        else $error("fabric packet length wrong");
    a_fab_reserved: assert property ( // RULE6
        tx_valid && cur_idx == 5'd5 && !r.rdma |-> tx_data[23:8] == 16'h0000)
        else $error("fabric reserved bits set");
    a_rdma_accept: assert property ( // RULE7
        req_ready && req_valid && req_stats_type == RDMA_CODE |=> r.st == PSRB_SEND && r.rdma
        ##1 tx_valid)
        else $error("RDMA request not started");
    a_rdma_length: assert property ( // RULE8
        tx_valid && tx_last && r.rdma |-> cur_idx == 5'd20)
        else $error("RDMA packet length wrong");
    a_rdma_sizes: assert property ( // RULE9
        tx_valid && cur_idx == 5'd5 && r.rdma |-> tx_data[23:16] == {1'b0, r.sizes})
        else $error("size bitmap wrong");
    a_rdma_reserved: assert property ( // RULE10
        tx_valid && cur_idx == 5'd5 && r.rdma |-> tx_data[15:7] == 9'h000)
        else $error("RDMA reserved bits set");
    a_upper_zero: assert property ( // RULE12
        tx_valid && r.rdma && cur_idx >= 5'd6 && cur_idx < 5'd20 && !cur_idx[0]
        && !r.sizes[3'((cur_idx - 5'd6) >> 1)] |-> tx_data == 32'h0000_0000)
        else $error("narrow upper word not zero");
    a_tx_hold: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("word dropped under back-pressure");
    a_apb_answer: assert property (
        psel && !penable |=> pready)
        else $error("no APB answer");

    a_ready_idle: assert property ( // RULE1
        req_ready |-> r.st == PSRB_IDLE && !tx_valid)
        else $error("ready while sending");
    a_type_idle: assert property ( // RULE1
        !tx_valid |-> tx_resp_type == 8'h00)
        else $error("type tag without word");
    a_last_valid: assert property ( // RULE4
        tx_last |-> tx_valid)
        else $error("last flag without word");
    a_word_hold: assert property ( // RULE4
        tx_valid && !tx_ready |=> $stable(tx_last) && $stable(r.idx))
        else $error("position moved under back-pressure");
    a_snap_type: assert property ( // RULE11
        r.st == PSRB_SEND |-> (r.snap & (r.rdma ? PSRB_FAB_MASK : PSRB_RDMA_MASK)) == 15'h0000)
        else $error("other type flags taken");

    a_apb_pulse: assert property (
        pready |=> !pready)
        else $error("APB answer held");
    a_err_zero: assert property (
        pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error with read data");
    a_off_refused: assert property (
        !r.en |-> !req_ready)
        else $error("request taken while off");
    a_sent_step: assert property (
        tx_valid && tx_ready && tx_last |=> r.sent == $past(r.sent) + 16'h0001)
        else $error("sent count not advanced");

    c_fab_done: cover property (@(posedge pclk) disable iff (!presetn)
        tx_valid && tx_ready && tx_last && !r.rdma);
    c_rdma_done: cover property (@(posedge pclk) disable iff (!presetn)
        tx_valid && tx_ready && tx_last && r.rdma);
    c_stall: cover property (@(posedge pclk) disable iff (!presetn)
        tx_valid && !tx_ready ##1 tx_valid && tx_ready);
    c_apb_write: cover property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite);
    c_narrow: cover property (@(posedge pclk) disable iff (!presetn)
        tx_valid && r.rdma && !r.sizes[0]);
endmodule
`default_nettype wire

// *** verif/psrb_sink_model.sv ***
// Response sink standing in for the management side of the stream.
// Assumes one pclk; stall sets how often ready is held off, out of 16.
`timescale 1ns/1ps
`default_nettype none
module psrb_sink_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    input wire logic tx_last,
    input wire logic [7:0] tx_resp_type,
    input wire logic [3:0] stall,
    output logic tx_ready
);
    logic [31:0] words [0:31];
    int count;
    int lastn;
    int npk;
    int type_bad;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
            count <= 0;
            lastn <= 0;
            npk <= 0;
            type_bad <= 0;
        end else begin
            // Random stalls, so every word has to stand until taken
            tx_ready <= (4'($urandom_range(15)) >= stall);
            if (tx_valid && tx_resp_type !== 8'hAF) begin
                type_bad <= type_bad + 1;
            end
            if (tx_valid && tx_ready) begin
                words[count[4:0]] <= tx_data;
                count <= tx_last ? 0 : count + 1;
                if (tx_last) begin
                    lastn <= count + 1;
                    npk <= npk + 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench of the partition statistics response builder.
// Assumes the sink model takes the response stream; APB is driven here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import psrb_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, req_ready, tx_valid, tx_last, tx_ready;
    logic [31:0] prdata, tx_data, rd;
    logic [7:0] tx_resp_type;
    logic req_valid = 1'b0;
    logic [7:0] req_stats_type = 8'h00;
    logic [127:0] req_header = '0;
    logic [15:0] req_resp_code = 16'h0000;
    logic [15:0] req_reason_code = 16'h0000;
    logic [255:0] fab_count = '0;
    logic [447:0] rdma_count = '0;
    logic [7:0] fab_cleared = 8'h00;
    logic [6:0] rdma_cleared = 7'h00;
    logic [3:0] stall = 4'h0;
    logic [14:0] stk = 15'h0000;
    logic [31:0] exp_w [0:31];
    logic err;
    int exp_n;
    int num_errors = 0;
    int check_count = 0;
    int sent = 0;

    psrb_builder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
        .req_stats_type(req_stats_type), .req_header(req_header),
        .req_resp_code(req_resp_code), .req_reason_code(req_reason_code),
        .fab_count(fab_count), .rdma_count(rdma_count), .fab_cleared(fab_cleared),
        .rdma_cleared(rdma_cleared), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_last(tx_last), .tx_resp_type(tx_resp_type), .tx_ready(tx_ready));
    psrb_sink_model sink (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_resp_type(tx_resp_type),
        .stall(stall), .tx_ready(tx_ready));

    initial begin
        forever #25 pclk = ~pclk;
    end

    task automatic report_and_stop();
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic timeout(input string what);
        num_errors++;
        $display("Error %s expected done seen timeout", what);
        report_and_stop();
    endtask

    // One transfer; an edge passes after release so calls never collide
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) timeout("apb");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic void expect_pkt(input logic rdma, input logic [127:0] hdr,
            input logic [15:0] rsn, input logic [6:0] sz);
        logic [31:0] sum;
        sum = 32'h0000_0000;
        exp_n = rdma ? 21 : 15;
        for (int i = 0; i < 4; i++)
            exp_w[i] = hdr[127 - 32 * i -: 32];
        // A command specific reason code is never passed on
        exp_w[4] = {hdr[15:0], rsn[15] ? 16'h0000 : rsn};
        exp_w[5] = rdma ? {PSRB_RDMA_CODE_DFLT, 1'b0, sz, 9'h000, stk[14:8]}
                        : {PSRB_FAB_CODE_DFLT, 16'h0000, stk[7:0]};
        for (int i = 0; i < 8; i++)
            exp_w[6 + i] = fab_count[32 * i +: 32];
        for (int k = 0; k < 7 && rdma; k++) begin
            exp_w[6 + 2 * k] = sz[k] ? rdma_count[64 * k + 32 +: 32] : 32'h0000_0000;
            exp_w[7 + 2 * k] = rdma_count[64 * k +: 32];
        end
        for (int i = 0; i < exp_n - 1; i++)
            sum += exp_w[i][31:16] + exp_w[i][15:0];
        exp_w[exp_n - 1] = -sum;
    endfunction

    task automatic packet(input logic rdma, input logic [15:0] rsn, input logic [6:0] sz);
        logic [127:0] hdr;
        int n;
        int p;
        hdr = {$urandom, $urandom, $urandom, $urandom};
        expect_pkt(rdma, hdr, rsn, sz);
        p = sink.npk;
        req_header <= hdr;
        req_reason_code <= rsn;
        req_resp_code <= hdr[15:0];
        req_stats_type <= rdma ? PSRB_RDMA_CODE_DFLT : PSRB_FAB_CODE_DFLT;
        req_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        req_valid <= 1'b0;
        while (sink.npk == p && n < 900) begin
            @(posedge pclk);
            n++;
        end
        if (sink.npk == p) timeout("packet");
        sent++;
        check("length", 32'(exp_n), 32'(sink.lastn));
        for (int i = 0; i < exp_n; i++)
            check($sformatf("word %0d", i), exp_w[i], sink.words[i]);
        check("type errors", 32'h0000_0000, 32'(sink.type_bad));
        stk = stk & (rdma ? PSRB_FAB_MASK : PSRB_RDMA_MASK);
    endtask

    initial begin
        logic [14:0] fl;
        logic [6:0] sz;
        void'($urandom(16));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, PSRB_ADDR_CTRL, 32'h0000_0000);
        check("ctrl reset", 32'h0000_0001, rd);
        apb(1'b0, PSRB_ADDR_SIZES, 32'h0000_0000);
        check("sizes reset", 32'h0000_007F, rd);
        apb(1'b0, 12'h020, 32'h0000_0000);
        check("unmapped error", 32'h0000_0001, {31'h0, err});
        sz = 7'h7F;
        for (int t = 0; t < 10; t++) begin
            fl = 15'($urandom);
            stall <= 4'($urandom_range(12));
            for (int i = 0; i < 8; i++)
                fab_count[32 * i +: 32] <= $urandom;
            for (int k = 0; k < 14; k++)
                rdma_count[32 * k +: 32] <= $urandom;
            fab_cleared <= fl[7:0];
            rdma_cleared <= fl[14:8];
            @(posedge pclk);
            fab_cleared <= 8'h00;
            rdma_cleared <= 7'h00;
            stk = stk | fl;
            if (t[0]) begin
                sz = (t == 3) ? 7'h00 : 7'($urandom);
                apb(1'b1, PSRB_ADDR_SIZES, {25'h0, sz});
            end
            apb(1'b0, PSRB_ADDR_FLAGS, 32'h0000_0000);
            check("flags before", {17'h0, stk}, rd);
            packet(t[0], (t == 2) ? 16'h8123 : 16'($urandom), sz);
            apb(1'b0, PSRB_ADDR_FLAGS, 32'h0000_0000);
            check("flags after", {17'h0, stk}, rd);
        end
        req_stats_type <= 8'h7E;
        req_valid <= 1'b1;
        repeat (3) @(posedge pclk);
        req_valid <= 1'b0;
        repeat (40) @(posedge pclk);
        check("discarded type", 32'(sent), 32'(sink.npk));
        apb(1'b1, PSRB_ADDR_SENT, 32'h0000_FFFF);
        apb(1'b0, PSRB_ADDR_SENT, 32'h0000_0000);
        check("sent count", 32'(sent), {16'h0, rd[15:0]});
        apb(1'b1, PSRB_ADDR_CTRL, 32'h0000_0000);
        @(posedge pclk);
        check("ready when off", 32'h0000_0000, {31'h0, req_ready});
        report_and_stop();
    end
endmodule
`default_nettype wire
